//--- verilog/clock_select_regs.vh
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

// ****
// register byte offsets
// ****
`define CTRL_OFFSET        8'h00
`define CRYSTAL_LOAD_CODE_OFFSET        8'h04
`define PLL_BASE_OFFSET    8'h08
`define OUTDIV_BASE_OFFSET 8'h1C
`define STATUS_OFFSET      8'h34
`define MULT_OFFSET        8'h38
`define LOADCAP_OFFSET     8'h3C
`define DIVIDE_OFFSET      8'h40
`define SSC_OFFSET         8'hAC

// ****
// field positions
// ****
`define CTRL_PRIM_BIT      0
`define CTRL_SM_LSB        1
`define CTRL_SM_MSB        2
`define CTRL_CRYSTAL_LOAD_CODE_BIT      3
`define CTRL_BANK_LSB      4
`define CTRL_BANK_MSB      6
`define CRYSTAL_LOAD_CODE_DRV_LSB       8
`define PLL_N_LSB          8
`define PLL_A_LSB          20
`define OUTDIV_PM_BIT      7
`define OUTDIV_OEM_LSB     8
`define SSC_SPREAD_LSB_RANDOMIZE_BIT       4
`define SSC_X2_BIT         5

// ****
// reset values and constants
// ****
`define CTRL_RESET         7'h00
`define CRYSTAL_LOAD_CODE_CODE_RESET    5'h00
`define CRYSTAL_LOAD_CODE_DRV_RESET     2'h3
`define PLL_D_RESET        7'h01
`define PLL_N_RESET        12'h000
`define Q_RESET            7'h00
`define Q_ALL_ONES         7'h7F
`define OEM_RESET          2'h1
`define LOADCAP_BASE       6'h1C
`define LOSS_CYCLES        2'h2
`define SSC_MIN_STEP       4'h5
`define SSC_MAX_STEP       4'hE
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- verilog/out_div_bank.v
`timescale 1ns/100ps
module out_div_bank (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       ref_tick,
   input  wire       ref_level,
   input  wire [8:0] div_value,
   input  wire [1:0] disabled_level,
   output reg        bank_out,
   output reg        bank_oe
);
   // ****
   // divider
   // ****
   reg [7:0] count_reg;
   wire [7:0] half_div = div_value[8:1];

   always @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= 8'h00;
         bank_out  <= 1'b0;
         bank_oe   <= 1'b0;
      end else if (div_value == 9'h000) begin
         // powered, no clock see R16
         count_reg <= 8'h00;
         bank_out  <= disabled_level[1];
         bank_oe   <= (disabled_level != 2'h0) && (disabled_level != 2'h3);
      end else if (div_value == 9'h001) begin
         bank_out  <= ref_level; // see R15
         bank_oe   <= 1'b1;
         count_reg <= 8'h00;
      end else begin
         bank_oe <= 1'b1;
         // toggles only on reference edges, but a switch
         // can still cut a half period short see R3
         if (ref_tick) begin
            if (count_reg + 8'h01 >= half_div) begin
               count_reg <= 8'h00;
               bank_out  <= ~bank_out; // see R13
            end else begin
               count_reg <= count_reg + 8'h01;
            end
         end
      end
   end
endmodule

//--- verilog/ref_clock_select.v
// Overview of operation
// R1 - primary bit: 0 crystal/ref input, 1 second input
// R2 - mode upper bit clear: manual, select pin chooses
// R3 - manual switch gives no output glitch; here the switch is immediate and can cut a half period short
// R4 - auto: secondary once primary idle two secondary cycles
// R5 - auto is revertive to a present primary
// R6 - auto only with crystal/ref input as primary
// R7 - no switching with a crystal fitted
// R8 - secondary no faster than primary
// R9 - switching asynchronous; routed references may pulse
// R10 - load cap 3.5 pF plus code times 0.125 pF
// R11 - external clock: load code 00h, drive 11h
// R12 - 7-bit reference, 12-bit feedback divider per PLL
// R13 - output is reference times multiplier over dividers; here banks only divide the reference, the multiplier is read back only
// R14 - first PLL multiplier 2N+A+1 if A nonzero, else 2N
// R15 - all-ones: off or /1; else /2 or (code+2)*2
// R16 - disabled bank high, low or high-z, stays powered
// R17 - output zero has no divider
// R18 - disable a divider only for an unused bank
// R19 - spread on while step field nonzero
// R20 - first PLL spread words at 0xAC to 0xBD
// R21 - mode upper bit set: automatic, select pin ignored
// R22 - step codes 5 to 14 valid only
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "clock_select_regs.vh"
module ref_clock_select (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        crystal_ref_input,
   input  wire        second_ref_input,
   input  wire        input_select_pin,
   output reg         undivided_output_zero,
   output wire [5:0]  bank_out,
   output wire [5:0]  bank_oe,
   output reg         on_secondary
);
   // ****
   // configuration registers
   // ****
   reg [6:0]  ctrl_reg;
   reg [4:0]  crystal_load_code_reg;
   reg [1:0]  oscillator_drive_strength_reg;
   reg [6:0]  pll_d_reg [0:3];
   reg [11:0] pll_n_reg [0:3];
   reg [3:0]  pll0_a_reg;
   reg [3:0]  ssc_step_reg;
   reg        spread_lsb_randomize_reg;
   reg        spread_amplitude_double_reg;
   reg [6:0]  q_reg [0:5];
   reg        out_div_prescale_bit_reg [0:5];
   reg [1:0]  disabled_output_level_reg [0:5];
   integer    i;

   wire       primary_source_select = ctrl_reg[`CTRL_PRIM_BIT];
   wire [1:0] switchover_mode_field = ctrl_reg[`CTRL_SM_MSB:`CTRL_SM_LSB];
   wire       crystal_mode          = ctrl_reg[`CTRL_CRYSTAL_LOAD_CODE_BIT];
   wire [2:0] bank_view             = ctrl_reg[`CTRL_BANK_MSB:`CTRL_BANK_LSB];

   // ****
   // helper functions
   // ****
   function [7:0] slot_addr;
      input [7:0] base;
      input [2:0] idx;
      begin
         slot_addr = base + {3'b000, idx, 2'b00};
      end
   endfunction

   function [8:0] total_output_divide;
      input [6:0] q;
      input       pm;
      begin
         if (q == `Q_ALL_ONES) begin
            total_output_divide = pm ? 9'h001 : 9'h000; // see R15
         end else if (pm) begin
            total_output_divide = {{1'b0, q} + 8'h02, 1'b0}; // see R15
         end else begin
            total_output_divide = 9'h002;
         end
      end
   endfunction

   wire [13:0] n_twice   = {1'b0, pll_n_reg[0], 1'b0};
   // A adds in only when nonzero see R14
   wire [13:0] pll0_mult = (pll0_a_reg != 4'h0) ?
                           n_twice + {10'h000, pll0_a_reg} + 14'h0001 : n_twice;
   wire        ssc_active  = (ssc_step_reg != 4'h0); // see R19
   wire        ssc_invalid = (ssc_step_reg < `SSC_MIN_STEP) ||
                             (ssc_step_reg > `SSC_MAX_STEP); // see R22
   wire [5:0]  load_cap    = `LOADCAP_BASE + {1'b0, crystal_load_code_reg}; // see R10
   reg         auto_active;

   function [8:0] bank_divide;
      input [2:0] b;
      begin
         // bank zero has no divider: reads /1 see R17
         if (b == 3'h0 || b > 3'h6) begin
            bank_divide = 9'h001;
         end else begin
            bank_divide = total_output_divide(q_reg[b - 3'h1],
                                              out_div_prescale_bit_reg[b - 3'h1]);
         end
      end
   endfunction

   function reg_mapped;
      input [7:0] a;
      begin
         reg_mapped = (a <= `DIVIDE_OFFSET && a[1:0] == 2'b00) ||
                      (a == `SSC_OFFSET);
      end
   endfunction

   function [31:0] reg_word;
      input [7:0] a;
      integer k;
      begin
         reg_word = 32'h0000_0000;
         if (a == `CTRL_OFFSET) reg_word = {25'h0, ctrl_reg};
         if (a == `CRYSTAL_LOAD_CODE_OFFSET)
            reg_word = {22'h0, oscillator_drive_strength_reg, 3'h0, crystal_load_code_reg};
         for (k = 0; k < 4; k = k + 1) begin
            if (a == slot_addr(`PLL_BASE_OFFSET, k[2:0])) begin
               reg_word = {8'h00, (k == 0) ? pll0_a_reg : 4'h0, pll_n_reg[k], 1'b0,
                           pll_d_reg[k]}; // see R12
            end
         end
         for (k = 0; k < 6; k = k + 1) begin
            if (a == slot_addr(`OUTDIV_BASE_OFFSET, k[2:0])) begin
               reg_word = {22'h0, disabled_output_level_reg[k],
                           out_div_prescale_bit_reg[k], q_reg[k]};
            end
         end
         if (a == `STATUS_OFFSET)
            reg_word = {28'h0, ssc_invalid, ssc_active, auto_active, on_secondary};
         if (a == `MULT_OFFSET)    reg_word = {18'h0, pll0_mult};
         if (a == `LOADCAP_OFFSET) reg_word = {26'h0, load_cap};
         if (a == `DIVIDE_OFFSET)  reg_word = {23'h0, bank_divide(bank_view)};
         if (a == `SSC_OFFSET) // see R20
            reg_word = {26'h0, spread_amplitude_double_reg, spread_lsb_randomize_reg,
                        ssc_step_reg};
      end
   endfunction

   // ****
   // axi4-lite write channel
   // ****
   reg        aw_got_reg;
   reg        w_got_reg;
   reg [7:0]  waddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   wire       do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
   wire [31:0] wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                          {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire [31:0] wword   = (reg_word(waddr_reg) & ~wmask) | (wdata_reg & wmask);

   assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         waddr_reg    <= 8'h00;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            waddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_mapped(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read-only words ignore writes
   // software keeps code and drive at defaults for a clock see R11
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg                      <= `CTRL_RESET;
         crystal_load_code_reg         <= `CRYSTAL_LOAD_CODE_CODE_RESET;
         oscillator_drive_strength_reg <= `CRYSTAL_LOAD_CODE_DRV_RESET;
         pll0_a_reg                    <= 4'h0;
         ssc_step_reg                  <= 4'h0;
         spread_lsb_randomize_reg      <= 1'b0;
         spread_amplitude_double_reg   <= 1'b0;
         for (i = 0; i < 4; i = i + 1) begin
            pll_d_reg[i] <= `PLL_D_RESET;
            pll_n_reg[i] <= `PLL_N_RESET;
         end
         for (i = 0; i < 6; i = i + 1) begin
            q_reg[i]                     <= `Q_RESET;
            out_div_prescale_bit_reg[i]  <= 1'b0;
            disabled_output_level_reg[i] <= `OEM_RESET;
         end
      end else if (do_write) begin
         if (waddr_reg == `CTRL_OFFSET) ctrl_reg <= wword[6:0];
         if (waddr_reg == `CRYSTAL_LOAD_CODE_OFFSET) begin
            crystal_load_code_reg         <= wword[4:0];
            oscillator_drive_strength_reg <= wword[`CRYSTAL_LOAD_CODE_DRV_LSB +: 2];
         end
         for (i = 0; i < 4; i = i + 1) begin
            if (waddr_reg == slot_addr(`PLL_BASE_OFFSET, i[2:0])) begin
               pll_d_reg[i] <= wword[6:0];
               pll_n_reg[i] <= wword[`PLL_N_LSB +: 12];
               if (i == 0) pll0_a_reg <= wword[`PLL_A_LSB +: 4];
            end
         end
         for (i = 0; i < 6; i = i + 1) begin
            if (waddr_reg == slot_addr(`OUTDIV_BASE_OFFSET, i[2:0])) begin
               q_reg[i]                     <= wword[6:0];
               out_div_prescale_bit_reg[i]  <= wword[`OUTDIV_PM_BIT];
               disabled_output_level_reg[i] <= wword[`OUTDIV_OEM_LSB +: 2];
            end
         end
         if (waddr_reg == `SSC_OFFSET) begin
            ssc_step_reg                <= wword[3:0];
            spread_lsb_randomize_reg    <= wword[`SSC_SPREAD_LSB_RANDOMIZE_BIT];
            spread_amplitude_double_reg <= wword[`SSC_X2_BIT];
         end
      end
   end

   // ****
   // axi4-lite read channel
   // ****
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= reg_word(s_axi_araddr);
         s_axi_rresp  <= reg_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****
   // pin synchronisers
   // ****
   // async pins: level taken when two stages agree see R9
   reg [2:0] xin_sync_reg;
   reg [2:0] cin_sync_reg;
   reg [2:0] sel_sync_reg;
   reg       xin_lvl_reg;
   reg       cin_lvl_reg;
   reg       sel_lvl_reg;
   reg       xin_prev_reg;
   reg       cin_prev_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         xin_sync_reg <= 3'h0;
         cin_sync_reg <= 3'h0;
         sel_sync_reg <= 3'h0;
         xin_lvl_reg  <= 1'b0;
         cin_lvl_reg  <= 1'b0;
         sel_lvl_reg  <= 1'b0;
         xin_prev_reg <= 1'b0;
         cin_prev_reg <= 1'b0;
      end else begin
         xin_sync_reg <= {xin_sync_reg[1:0], crystal_ref_input};
         cin_sync_reg <= {cin_sync_reg[1:0], second_ref_input};
         sel_sync_reg <= {sel_sync_reg[1:0], input_select_pin};
         if (xin_sync_reg[1] == xin_sync_reg[2]) xin_lvl_reg <= xin_sync_reg[2];
         if (cin_sync_reg[1] == cin_sync_reg[2]) cin_lvl_reg <= cin_sync_reg[2];
         if (sel_sync_reg[1] == sel_sync_reg[2]) sel_lvl_reg <= sel_sync_reg[2];
         xin_prev_reg <= xin_lvl_reg;
         cin_prev_reg <= cin_lvl_reg;
      end
   end

   // ****
   // reference selection
   // ****
   wire pri_lvl  = primary_source_select ? cin_lvl_reg : xin_lvl_reg; // see R1
   wire sec_lvl  = primary_source_select ? xin_lvl_reg : cin_lvl_reg; // see R1
   wire pri_prev = primary_source_select ? cin_prev_reg : xin_prev_reg;
   wire sec_prev = primary_source_select ? xin_prev_reg : cin_prev_reg;
   wire pri_edge = pri_lvl ^ pri_prev;
   wire sec_rise = sec_lvl & ~sec_prev;
   reg  [1:0] loss_count_reg;

   always @* begin
      // auto: crystal/ref primary, no crystal see R6 see R7
      auto_active = switchover_mode_field[1] && !primary_source_select && !crystal_mode;
   end

   // assumes secondary no faster than primary see R8
   always @(posedge aclk) begin
      if (!aresetn) begin
         loss_count_reg <= 2'h0;
         on_secondary   <= 1'b0;
      end else if (crystal_mode) begin
         loss_count_reg <= 2'h0;
         on_secondary   <= 1'b0; // see R7
      end else if (!switchover_mode_field[1]) begin
         loss_count_reg <= 2'h0;
         on_secondary   <= sel_lvl_reg; // see R2
      end else if (!auto_active) begin
         loss_count_reg <= 2'h0;
         on_secondary   <= 1'b0; // see R6
      end else if (pri_edge) begin
         // select pin has no say here see R21
         loss_count_reg <= 2'h0;
         on_secondary   <= 1'b0; // see R5
      end else if (sec_rise) begin
         if (loss_count_reg + 2'h1 >= `LOSS_CYCLES) begin
            on_secondary <= 1'b1; // see R4
         end
         if (loss_count_reg != `LOSS_CYCLES) loss_count_reg <= loss_count_reg + 2'h1;
      end
   end

   wire sel_level = on_secondary ? sec_lvl : pri_lvl;
   wire sel_prev  = on_secondary ? sec_prev : pri_prev;
   wire sel_tick  = sel_level & ~sel_prev;

   // ****
   // output banks
   // ****
   always @(posedge aclk) begin
      if (!aresetn) begin
         undivided_output_zero <= 1'b0;
      end else begin
         undivided_output_zero <= sel_level; // see R17
      end
   end

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : bank
         out_div_bank u_bank (
            .aclk           (aclk),
            .aresetn        (aresetn),
            .ref_tick       (sel_tick),
            .ref_level      (sel_level),
            .div_value      (total_output_divide(q_reg[g], out_div_prescale_bit_reg[g])),
            .disabled_level (disabled_output_level_reg[g]),
            .bank_out       (bank_out[g]),
            .bank_oe        (bank_oe[g])
         );
      end
   endgenerate
endmodule

//--- tb/ref_clock_select_properties.sv
`timescale 1ns/100ps
module ref_clock_select_properties (
   input wire        aclk,
   input wire        aresetn,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        crystal_ref_input,
   input wire        second_ref_input,
   input wire        input_select_pin,
   input wire        on_secondary
);
   // ****
   // mode snoop and loss counter
   // ****
   reg  [3:0] ctrl_reg;
   reg  [1:0] cnt_reg;
   reg        sec_reg;
   reg        prim_reg;
   wire       auto_on = ctrl_reg[2] && !ctrl_reg[0] && !ctrl_reg[3];
   wire       wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                        && s_axi_awaddr == 8'h00;
   wire       prim_edge = prim_reg != crystal_ref_input;

   // raw pins: counts lead the design by its sync delay
   always @(posedge aclk) begin
      sec_reg  <= second_ref_input;
      prim_reg <= crystal_ref_input;
      if (!aresetn)
         ctrl_reg <= 4'h0;
      else if (wr_ctrl)
         ctrl_reg <= s_axi_wdata[3:0];
      if (!aresetn || !auto_on || prim_edge)
         cnt_reg <= 2'h0;
      else if (second_ref_input && !sec_reg && cnt_reg != 2'h3)
         cnt_reg <= cnt_reg + 2'h1;
   end

   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_manual_follow: assert property (
      (!ctrl_reg[2] && !ctrl_reg[3] && $stable(input_select_pin))[*8]
      |-> on_secondary == input_select_pin) else $error("selection ignores select pin");
   chk_crystal_off: assert property (
      ctrl_reg[3] && $past(ctrl_reg[3], 3) |-> !on_secondary) else $error("switch with crystal");
   chk_prim_fixed: assert property (
      ctrl_reg[2] && ctrl_reg[0] && $past(ctrl_reg, 3) == ctrl_reg |-> !on_secondary)
      else $error("auto switch with second input primary");
   chk_loss_switch: assert property (
      auto_on && cnt_reg == 2'h3 |-> on_secondary) else $error("no switch on primary loss");
   chk_auto_revert: assert property (
      auto_on && on_secondary && prim_edge |-> ##[1:12] !on_secondary)
      else $error("no return to primary");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
   chk_busy_refuse: assert property (
      s_axi_bvalid || s_axi_rvalid |-> !(s_axi_awready && s_axi_bvalid) && !(s_axi_arready
      && s_axi_rvalid)) else $error("request taken while answer pending");

   cover property (auto_on && $rose(on_secondary));
   cover property (auto_on && $fell(on_secondary));
   cover property (wr_ctrl && s_axi_wdata[3:0] == 4'hC);
endmodule

bind ref_clock_select ref_clock_select_properties chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .crystal_ref_input(crystal_ref_input), .second_ref_input(second_ref_input),
   .input_select_pin(input_select_pin), .on_secondary(on_secondary)
);

//--- tb/ref_sources.sv
`timescale 1ns/100ps
module ref_sources (
   input wire       xin_run,
   input wire       cin_run,
   input wire [7:0] xin_half,
   input wire [7:0] cin_half,
   output reg       crystal_ref_input,
   output reg       second_ref_input
);
   // ****
   // two reference sources, parked when stopped
   // ****
   // second input no faster than crystal
   wire [7:0] cin_eff = (cin_half < xin_half) ? xin_half : cin_half;

   initial crystal_ref_input = 1'h0;
   initial second_ref_input = 1'h0;
   // parked levels differ so the chosen source is visible
   always begin
      #(xin_half * 10);
      crystal_ref_input = xin_run ? ~crystal_ref_input : 1'h0;
   end
   always begin
      #(cin_eff * 10);
      second_ref_input = cin_run ? ~second_ref_input : 1'h1;
   end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
`include "clock_select_regs.vh"
module testbench;
   // ****
   // stimulus, scoreboard and sequence
   // ****
   reg         aclk = 1'h0;
   reg         aresetn = 1'h0;
   reg  [7:0]  awaddr = 8'h00;
   reg  [7:0]  araddr = 8'h00;
   reg  [31:0] wdata = 32'h0;
   reg         awvalid = 1'h0;
   reg         wvalid = 1'h0;
   reg         bready = 1'h0;
   reg         arvalid = 1'h0;
   reg         rready = 1'h0;
   reg         sel_pin = 1'h0;
   reg         xin_run = 1'h1;
   reg         cin_run = 1'h1;
   wire        awready, wready, bvalid, arready, rvalid, zero_out, on_sec, xin, cin;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [5:0]  bank_out, bank_oe;
   reg  [1:0]  wq[$];
   reg  [33:0] rq[$];
   integer     n_fail, check_count, seed, i, j, n, a;

   ref_clock_select DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .crystal_ref_input(xin), .second_ref_input(cin), .input_select_pin(sel_pin),
      .undivided_output_zero(zero_out), .bank_out(bank_out), .bank_oe(bank_oe),
      .on_secondary(on_sec)
   );
   ref_sources src (
      .xin_run(xin_run), .cin_run(cin_run), .xin_half(8'h06), .cin_half(8'h14),
      .crystal_ref_input(xin), .second_ref_input(cin)
   );

   always #5 aclk = ~aclk;

   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   task cmp(input string nm, input [33:0] exp, input [33:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask

   task timeout;
      begin
         n_fail = n_fail + 1;
         $display("Error handshake expected answer seen none");
         give_verdict;
      end
   endtask

   // one edge first, so no signal is assigned twice in a time step
   task axi_wr(input [7:0] ad, input [31:0] d, input [1:0] r);
      integer k;
      begin
         @(posedge aclk);
         wq.push_back(r);
         awaddr  <= ad;
         wdata   <= d;
         awvalid <= 1'h1;
         wvalid  <= 1'h1;
         bready  <= 1'h1;
         for (k = 0; k < 40 && !(bvalid === 1'h1 && !awvalid && !wvalid); k = k + 1) begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
         end
         bready <= 1'h0;
         if (k == 40) timeout;
      end
   endtask

   task axi_rd(input [7:0] ad, input [33:0] e);
      integer k;
      begin
         @(posedge aclk);
         rq.push_back(e);
         araddr  <= ad;
         arvalid <= 1'h1;
         rready  <= 1'h1;
         for (k = 0; k < 40 && !(rvalid === 1'h1 && !arvalid); k = k + 1) begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
         end
         rready <= 1'h0;
         if (k == 40) timeout;
      end
   endtask

   task wait_sec(input v);
      integer k;
      begin
         for (k = 0; k < 400 && on_sec !== v; k = k + 1) @(posedge aclk);
         cmp("on_secondary", {33'h0, v}, {33'h0, on_sec});
      end
   endtask

   // longer than two slow secondary periods
   task hold_chk;
      begin
         repeat (200) @(posedge aclk);
         cmp("on_secondary", 34'h0, {33'h0, on_sec});
      end
   endtask

   always @(posedge aclk) begin
      if (bvalid === 1'h1 && bready) cmp("bresp", {32'h0, wq.pop_front()}, {32'h0, bresp});
      if (rvalid === 1'h1 && rready) cmp("rdata", rq.pop_front(), {rresp, rdata});
   end

   initial begin
      n_fail = 0;
      check_count = 0;
      seed = 32'heb82;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(`CTRL_OFFSET, 34'h0);
      axi_rd(`CRYSTAL_LOAD_CODE_OFFSET, 34'h300);
      axi_rd(`PLL_BASE_OFFSET, 34'h1);
      axi_rd(`OUTDIV_BASE_OFFSET, 34'h100);
      axi_rd(`STATUS_OFFSET, 34'h8);
      axi_rd(8'h44, {`RESP_SLVERR, 32'h0});
      axi_wr(8'h44, 32'h1, `RESP_SLVERR);
      axi_wr(`STATUS_OFFSET, 32'hF, `RESP_OKAY);
      axi_rd(`STATUS_OFFSET, 34'h8);
      $display("test reset and map done");
      for (i = 0; i < 4; i = i + 1) begin
         j = (i == 0) ? 31 : {$random(seed)} % 32;
         axi_wr(`CRYSTAL_LOAD_CODE_OFFSET, j, `RESP_OKAY);
         axi_rd(`LOADCAP_OFFSET, 34'h1C + j);
      end
      axi_wr(`CRYSTAL_LOAD_CODE_OFFSET, 32'h300, `RESP_OKAY);
      axi_wr(8'h0C, 32'h000FFF7F, `RESP_OKAY);
      axi_rd(8'h0C, 34'h000FFF7F);
      for (i = 0; i < 3; i = i + 1) begin
         n = {$random(seed)} % 4096;
         a = (i == 0) ? 0 : {$random(seed)} % 16;
         axi_wr(`PLL_BASE_OFFSET, (a << 20) | (n << 8) | 1, `RESP_OKAY);
         axi_rd(`MULT_OFFSET, (a == 0) ? 2 * n : 2 * n + a + 1);
      end
      $display("test dividers done");
      for (i = 0; i < 4; i = i + 1) begin
         j = 1 + {$random(seed)} % 6;
         n = (i < 2) ? 127 : {$random(seed)} % 127;
         a = (i < 3) ? i : (n + 2) * 2;
         axi_wr(`OUTDIV_BASE_OFFSET + 4 * (j - 1), n | ((i & 1) << 7), `RESP_OKAY);
         axi_wr(`CTRL_OFFSET, j << 4, `RESP_OKAY);
         axi_rd(`DIVIDE_OFFSET, a);
      end
      axi_wr(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
      axi_rd(`DIVIDE_OFFSET, 34'h1);
      for (i = 0; i < 4; i = i + 1) begin
         axi_wr(`OUTDIV_BASE_OFFSET, (i << 8) | 32'h7F, `RESP_OKAY);
         repeat (4) @(posedge aclk);
         cmp("bank_oe", i == 1 || i == 2, bank_oe[0]);
         if (i == 1 || i == 2) cmp("bank_out", i >> 1, bank_out[0]);
      end
      for (i = 0; i < 16; i = i + 1) begin
         axi_wr(`SSC_OFFSET, i | 32'h30, `RESP_OKAY);
         axi_rd(`SSC_OFFSET, i | 32'h30);
         axi_rd(`STATUS_OFFSET, ((i < 5 || i > 14) << 3) | ((i != 0) << 2));
      end
      $display("test banks and spread done");
      xin_run <= 1'h0;
      cin_run <= 1'h0;
      for (i = 0; i < 4; i = i + 1) begin
         axi_wr(`CTRL_OFFSET, i >> 1, `RESP_OKAY);
         sel_pin <= i & 1;
         wait_sec(i & 1);
         repeat (8) @(posedge aclk);
         cmp("undivided_output_zero", ((i >> 1) ^ i) & 1 ? cin : xin, zero_out);
      end
      sel_pin <= 1'h0;
      xin_run <= 1'h1;
      cin_run <= 1'h1;
      axi_wr(`CTRL_OFFSET, 32'h4, `RESP_OKAY);
      sel_pin <= 1'h1;
      hold_chk;
      xin_run <= 1'h0;
      wait_sec(1'h1);
      xin_run <= 1'h1;
      wait_sec(1'h0);
      for (i = 0; i < 2; i = i + 1) begin
         axi_wr(`CTRL_OFFSET, i ? 32'hC : 32'h5, `RESP_OKAY);
         if (i) xin_run <= 1'h0;
         else cin_run <= 1'h0;
         hold_chk;
         xin_run <= 1'h1;
         cin_run <= 1'h1;
      end
      $display("test switchover done");
      give_verdict;
   end
endmodule
